// File: include/cmpctl_pkg.sv
// Constants and carrier types for the dual comparator control block.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package cmpctl_pkg;

  // Bus and block dimensions.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned N_CMP  = 2;
  localparam int unsigned PORT_W = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL_A0  = 8'h00;
  localparam logic [7:0] OFS_CTRL_B0  = 8'h04;
  localparam logic [7:0] OFS_CTRL_A1  = 8'h08;
  localparam logic [7:0] OFS_CTRL_B1  = 8'h0C;
  localparam logic [7:0] OFS_MIRROR   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h1C;
  localparam logic [7:0] OFS_PORT     = 8'h20;
  localparam logic [7:0] OFS_ANSEL    = 8'h24;

  // Field positions of comparator_control_a.
  localparam int unsigned A_ENABLE = 7;
  localparam int unsigned A_RESULT = 6;
  localparam int unsigned A_PIN_OE = 5;
  localparam int unsigned A_INVERT = 4;
  localparam int unsigned A_SPEED  = 2;
  localparam int unsigned A_HYST   = 1;
  localparam int unsigned A_SYNC   = 0;

  // Field positions of comparator_control_b.
  localparam int unsigned B_RISE   = 7;
  localparam int unsigned B_FALL   = 6;
  localparam int unsigned B_POS_LO = 4;
  localparam int unsigned B_NEG_LO = 0;

  // Writable bit masks and reset values.
  localparam logic [7:0] CTRL_A_WMASK = 8'hB7;
  localparam logic [7:0] CTRL_B_WMASK = 8'hF3;
  localparam logic [7:0] CTRL_A_RST   = 8'h04;
  localparam logic [7:0] CTRL_B_RST   = 8'h00;
  localparam logic [7:0] ANSEL_RST    = 8'hFF;

  // Positive input select codes.
  localparam logic [1:0] POS_OWN    = 2'h0;
  localparam logic [1:0] POS_DAC    = 2'h1;
  localparam logic [1:0] POS_FIXREF = 2'h2;
  localparam logic [1:0] POS_SHARED = 2'h3;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Digital settings that one comparator channel needs.
  typedef struct packed {
    logic enable;
    logic invert;
    logic sync_mode;
  } cmpctl_cfg_t;

  // Controls driven into one analog comparator core, one-hot muxes.
  typedef struct packed {
    logic       enable;
    logic       speed_high;
    logic       hyst;
    logic       pos_own;
    logic       pos_dac;
    logic       pos_fixref;
    logic       pos_shared;
    logic       pos_gnd;
    logic [3:0] neg_pin;
  } cmpctl_core_t;

  // State of one comparator channel.
  typedef struct packed {
    logic s1;
    logic s2;
    logic res;
    logic pin;
    logic rise;
    logic fall;
  } cmpctl_chan_st_t;

endpackage

// File: verilog/cmpctl_chan.sv
// One comparator channel: synchroniser, polarity, edges, timer-synchronous latch.
// Assumes tmr1_fall is a one-cycle pulse on the falling edge of the timer clock.
`timescale 1ns/1ps
module cmpctl_chan (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   raw,
  input  wire cmpctl_pkg::cmpctl_cfg_t cfg,
  input  wire logic                   tmr1_fall,
  output logic                        result,
  output logic                        pin_result,
  output logic                        rise,
  output logic                        fall
);

  cmpctl_pkg::cmpctl_chan_st_t st_r;
  cmpctl_pkg::cmpctl_chan_st_t st_nxt;

  // A disabled core reads low before polarity, so toggling enable or invert makes edges.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = raw;
    st_nxt.s2   = st_r.s1;
    st_nxt.res  = (st_r.s2 & cfg.enable) ^ cfg.invert;
    st_nxt.rise = ~st_r.res & st_nxt.res;
    st_nxt.fall = st_r.res & ~st_nxt.res;
    // In sync mode the timer copy holds between timer falling edges so the counter never races it.
    if (!cfg.sync_mode || tmr1_fall) begin
      st_nxt.pin = st_nxt.res;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign result     = st_r.res;
  assign pin_result = st_r.pin;
  assign rise       = st_r.rise;
  assign fall       = st_r.fall;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Checks on the channel.
  AST_SYNC_HOLD: assert property (cfg.sync_mode && !tmr1_fall |=> $stable(st_r.pin))
    else $error("pin result moved without a timer falling edge");
  AST_EDGE_PULSE: assert property (st_r.rise |-> st_r.res && !$past(st_r.res))
    else $error("rise pulse without a low to high result change");
  CVR_SYNC_LATCH: cover property (cfg.sync_mode && tmr1_fall ##1 $changed(st_r.pin));

endmodule // cmpctl_chan

// File: verilog/cmpctl_top.sv
// Dual comparator control block with an AXI4-Lite register slave.
// Assumes the analog cores, the timer clock and pin directions are outside.
//
// Behaviour
// - Control A bit 7 enables its comparator; read/write, resets low.
// - Control A bit 6 reads result: high when positive input exceeds negative.
// - Control A bit 5 drives result on pin only when pin direction is output.
// - Control A bit 4 inverts result for status, edges and all users.
// - Control A bit 2 resets high for fast mode; low selects low power.
// - Control A bit 1 enables core hysteresis; resets low.
// - Control A bit 0 makes timer and pin copy update on timer falling edges.
// - Control B bit 7 lets a rising result set the interrupt flag.
// - Control B bit 6 lets a falling result set the interrupt flag.
// - Positive select 00 own pin, 01 DAC, 10 fixed voltage reference.
// - Positive select 11: first comparator shared pin, second comparator ground.
// - Negative select picks shared pin 0 to 3; bits 3-2 read zero.
// - Mirror register: second result bit 1, first result bit 0, rest zero.
// - Port reads return zero for every pin set as analog input.
// - An enabled detected edge sets the comparator interrupt flag.
// - Software clears the flag; an edge during the clear keeps it set.
// - Toggling invert or enable makes an edge even while disabled.
// - Status result is latched each clock; pin copy too, but only on timer falling edges in sync mode.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module cmpctl_top (
  input  wire logic                                        clk,
  input  wire logic                                        arst_n,
  input  wire logic [cmpctl_pkg::ADDR_W-1:0]               s_axi_awaddr,
  input  wire logic [2:0]                                  s_axi_awprot,
  input  wire logic                                        s_axi_awvalid,
  output logic                                             s_axi_awready,
  input  wire logic [cmpctl_pkg::DATA_W-1:0]               s_axi_wdata,
  input  wire logic [3:0]                                  s_axi_wstrb,
  input  wire logic                                        s_axi_wvalid,
  output logic                                             s_axi_wready,
  output logic [1:0]                                       s_axi_bresp,
  output logic                                             s_axi_bvalid,
  input  wire logic                                        s_axi_bready,
  input  wire logic [cmpctl_pkg::ADDR_W-1:0]               s_axi_araddr,
  input  wire logic [2:0]                                  s_axi_arprot,
  input  wire logic                                        s_axi_arvalid,
  output logic                                             s_axi_arready,
  output logic [cmpctl_pkg::DATA_W-1:0]                    s_axi_rdata,
  output logic [1:0]                                       s_axi_rresp,
  output logic                                             s_axi_rvalid,
  input  wire logic                                        s_axi_rready,
  input  wire logic [cmpctl_pkg::N_CMP-1:0]                cmp_raw,
  input  wire logic                                        tmr1_clk,
  input  wire logic [cmpctl_pkg::N_CMP-1:0]                pin_direction_bit,
  input  wire logic [cmpctl_pkg::PORT_W-1:0]               port_pin_in,
  output cmpctl_pkg::cmpctl_core_t [cmpctl_pkg::N_CMP-1:0] cmp_core_ctrl,
  output logic [cmpctl_pkg::N_CMP-1:0]                     cmp_pin_out,
  output logic [cmpctl_pkg::N_CMP-1:0]                     cmp_pin_oe_n,
  output logic [cmpctl_pkg::N_CMP-1:0]                     cmp_timer1_out,
  output logic                                             irq
);

  // Whole block state in one record.
  typedef struct packed {
    logic [cmpctl_pkg::N_CMP-1:0][7:0]                ctrl_a;
    logic [cmpctl_pkg::N_CMP-1:0][7:0]                ctrl_b;
    logic [cmpctl_pkg::N_CMP-1:0]                     irq_stat;
    logic [cmpctl_pkg::N_CMP-1:0]                     irq_en;
    logic [cmpctl_pkg::PORT_W-1:0]                    ansel;
    logic                                             aw_have;
    logic [cmpctl_pkg::ADDR_W-1:0]                    awaddr;
    logic                                             w_have;
    logic [7:0]                                       wbyte;
    logic                                             wlane0;
    logic                                             awready;
    logic                                             wready;
    logic                                             bvalid;
    logic [1:0]                                       bresp;
    logic                                             arready;
    logic                                             rvalid;
    logic [1:0]                                       rresp;
    logic [7:0]                                       rbyte;
    logic                                             t1_prev;
    cmpctl_pkg::cmpctl_core_t [cmpctl_pkg::N_CMP-1:0] core;
    logic [cmpctl_pkg::N_CMP-1:0]                     pin_out;
    logic [cmpctl_pkg::N_CMP-1:0]                     pin_oe_n;
    logic [cmpctl_pkg::N_CMP-1:0]                     t1_out;
    logic                                             irq;
  } cmpctl_top_st_t;

  cmpctl_top_st_t                      st_r;
  cmpctl_top_st_t                      st_nxt;
  cmpctl_pkg::cmpctl_cfg_t [cmpctl_pkg::N_CMP-1:0] cfg;
  logic [cmpctl_pkg::N_CMP-1:0]        res;
  logic [cmpctl_pkg::N_CMP-1:0]        pin_res;
  logic [cmpctl_pkg::N_CMP-1:0]        rise;
  logic [cmpctl_pkg::N_CMP-1:0]        fall;
  logic                                tmr1_fall;

  // Decodes one comparator's control pair into analog core controls.
  // A disabled comparator has every input switch open to save current.
  function automatic cmpctl_pkg::cmpctl_core_t core_dec(
    input logic [7:0] ca,
    input logic [7:0] cb,
    input logic       second
  );
    cmpctl_pkg::cmpctl_core_t c;
    logic [1:0]               ps;
    logic [1:0]               ns;
    logic                     on;
    c          = '0;
    on         = ca[cmpctl_pkg::A_ENABLE];
    ps         = cb[cmpctl_pkg::B_POS_LO +: 2];
    ns         = cb[cmpctl_pkg::B_NEG_LO +: 2];
    c.enable     = on;
    c.speed_high = ca[cmpctl_pkg::A_SPEED];
    c.hyst       = ca[cmpctl_pkg::A_HYST];
    c.pos_own    = on && (ps == cmpctl_pkg::POS_OWN);
    c.pos_dac    = on && (ps == cmpctl_pkg::POS_DAC);
    c.pos_fixref = on && (ps == cmpctl_pkg::POS_FIXREF);
    c.pos_shared = on && (ps == cmpctl_pkg::POS_SHARED) && !second;
    c.pos_gnd    = on && (ps == cmpctl_pkg::POS_SHARED) && second;
    c.neg_pin    = on ? (4'h1 << ns) : 4'h0;
    return c;
  endfunction

  // Timer clock is sampled as a synchronous input; its falling edge paces sync mode.
  assign tmr1_fall = st_r.t1_prev & ~tmr1_clk;

  // Channel settings from the control registers.
  always_comb begin
    for (int i = 0; i < cmpctl_pkg::N_CMP; i++) begin
      cfg[i].enable    = st_r.ctrl_a[i][cmpctl_pkg::A_ENABLE];
      cfg[i].invert    = st_r.ctrl_a[i][cmpctl_pkg::A_INVERT];
      cfg[i].sync_mode = st_r.ctrl_a[i][cmpctl_pkg::A_SYNC];
    end
  end

  for (genvar g = 0; g < cmpctl_pkg::N_CMP; g++) begin : g_chan
    cmpctl_chan u_chan (
      .clk        (clk),
      .arst_n     (arst_n),
      .raw        (cmp_raw[g]),
      .cfg        (cfg[g]),
      .tmr1_fall  (tmr1_fall),
      .result     (res[g]),
      .pin_result (pin_res[g]),
      .rise       (rise[g]),
      .fall       (fall[g])
    );
  end

  // Next state: bus slave, registers, interrupt flags and pin drive.
  always_comb begin
    logic [cmpctl_pkg::N_CMP-1:0] clr;
    logic [cmpctl_pkg::N_CMP-1:0] set_v;
    logic [7:0]                   wb;
    logic [7:0]                   rb;
    logic                         rok;
    st_nxt = st_r;
    clr    = '0;
    set_v  = '0;
    wb     = st_r.wbyte;
    rb     = 8'h00;
    rok    = 1'b1;
    st_nxt.t1_prev = tmr1_clk;

    // Address and data are taken independently, in either order.
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wbyte  = s_axi_wdata[7:0];
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Registers hold only the low byte, so only lane 0 can change them.
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = cmpctl_pkg::RESP_OKAY;
      case (st_r.awaddr)
        cmpctl_pkg::OFS_CTRL_A0: begin
          if (st_r.wlane0) st_nxt.ctrl_a[0] = wb & cmpctl_pkg::CTRL_A_WMASK;
        end
        cmpctl_pkg::OFS_CTRL_A1: begin
          if (st_r.wlane0) st_nxt.ctrl_a[1] = wb & cmpctl_pkg::CTRL_A_WMASK;
        end
        cmpctl_pkg::OFS_CTRL_B0: begin
          if (st_r.wlane0) st_nxt.ctrl_b[0] = wb & cmpctl_pkg::CTRL_B_WMASK;
        end
        cmpctl_pkg::OFS_CTRL_B1: begin
          if (st_r.wlane0) st_nxt.ctrl_b[1] = wb & cmpctl_pkg::CTRL_B_WMASK;
        end
        cmpctl_pkg::OFS_IRQ_CLR: begin
          if (st_r.wlane0) clr = wb[cmpctl_pkg::N_CMP-1:0];
        end
        cmpctl_pkg::OFS_IRQ_EN: begin
          if (st_r.wlane0) st_nxt.irq_en = wb[cmpctl_pkg::N_CMP-1:0];
        end
        cmpctl_pkg::OFS_ANSEL: begin
          if (st_r.wlane0) st_nxt.ansel = wb;
        end
        cmpctl_pkg::OFS_MIRROR, cmpctl_pkg::OFS_IRQ_STAT, cmpctl_pkg::OFS_PORT: begin
          st_nxt.bresp = cmpctl_pkg::RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = cmpctl_pkg::RESP_SLVERR;
        end
      endcase
    end
    st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;

    // Read data is decoded from the address and captured with it.
    case (s_axi_araddr)
      cmpctl_pkg::OFS_CTRL_A0: rb = st_r.ctrl_a[0] | {1'b0, res[0], 6'h00};
      cmpctl_pkg::OFS_CTRL_A1: rb = st_r.ctrl_a[1] | {1'b0, res[1], 6'h00};
      cmpctl_pkg::OFS_CTRL_B0: rb = st_r.ctrl_b[0];
      cmpctl_pkg::OFS_CTRL_B1: rb = st_r.ctrl_b[1];
      cmpctl_pkg::OFS_MIRROR:   rb = {6'h00, res[1], res[0]};
      cmpctl_pkg::OFS_IRQ_STAT: rb = {6'h00, st_r.irq_stat};
      cmpctl_pkg::OFS_IRQ_CLR:  rb = 8'h00;
      cmpctl_pkg::OFS_IRQ_EN:   rb = {6'h00, st_r.irq_en};
      cmpctl_pkg::OFS_PORT:     rb = port_pin_in & ~st_r.ansel;
      cmpctl_pkg::OFS_ANSEL:    rb = st_r.ansel;
      default:                  rok = 1'b0;
    endcase
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rbyte  = rb;
      st_nxt.rresp  = rok ? cmpctl_pkg::RESP_OKAY : cmpctl_pkg::RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Flags are sticky; a new edge outranks a clear in the same cycle.
    for (int i = 0; i < cmpctl_pkg::N_CMP; i++) begin
      set_v[i] = (rise[i] && st_r.ctrl_b[i][cmpctl_pkg::B_RISE])
              || (fall[i] && st_r.ctrl_b[i][cmpctl_pkg::B_FALL]);
    end
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | set_v;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_en);

    // Pin drive ignores the enable bit; the direction bit must select output.
    for (int i = 0; i < cmpctl_pkg::N_CMP; i++) begin
      st_nxt.core[i]     = core_dec(st_nxt.ctrl_a[i], st_nxt.ctrl_b[i], i[0]);
      st_nxt.pin_oe_n[i] = !(st_r.ctrl_a[i][cmpctl_pkg::A_PIN_OE]
                             && !pin_direction_bit[i]);
    end
    st_nxt.pin_out = pin_res;
    st_nxt.t1_out  = pin_res;
  end

  // Reset values: control A fast mode set, all pins analog, bus idle but ready.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r          <= '0;
      st_r.ctrl_a   <= {cmpctl_pkg::N_CMP{cmpctl_pkg::CTRL_A_RST}};
      st_r.ctrl_b   <= {cmpctl_pkg::N_CMP{cmpctl_pkg::CTRL_B_RST}};
      st_r.ansel    <= cmpctl_pkg::ANSEL_RST;
      st_r.awready  <= 1'b1;
      st_r.wready   <= 1'b1;
      st_r.arready  <= 1'b1;
      st_r.pin_oe_n <= {cmpctl_pkg::N_CMP{1'b1}};
      for (int i = 0; i < cmpctl_pkg::N_CMP; i++) begin
        st_r.core[i].speed_high <= 1'b1;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready  = st_r.awready;
  assign s_axi_wready   = st_r.wready;
  assign s_axi_bvalid   = st_r.bvalid;
  assign s_axi_bresp    = st_r.bresp;
  assign s_axi_arready  = st_r.arready;
  assign s_axi_rvalid   = st_r.rvalid;
  assign s_axi_rresp    = st_r.rresp;
  assign s_axi_rdata    = {24'h000000, st_r.rbyte};
  assign cmp_core_ctrl  = st_r.core;
  assign cmp_pin_out    = st_r.pin_out;
  assign cmp_pin_oe_n   = st_r.pin_oe_n;
  assign cmp_timer1_out = st_r.t1_out;
  assign irq            = st_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Checks on flags, read data and pin drive.
  AST_RISE_SETS: assert property (
    rise[0] && st_r.ctrl_b[0][cmpctl_pkg::B_RISE] |=> st_r.irq_stat[0])
    else $error("enabled rising edge did not set flag 0");
  AST_RISE_SETS_1: assert property (
    rise[1] && st_r.ctrl_b[1][cmpctl_pkg::B_RISE] |=> st_r.irq_stat[1])
    else $error("enabled rising edge did not set flag 1");
  AST_FALL_SETS: assert property (
    fall[1] && st_r.ctrl_b[1][cmpctl_pkg::B_FALL] |=> st_r.irq_stat[1])
    else $error("enabled falling edge did not set flag 1");
  AST_FALL_SETS_0: assert property (
    fall[0] && st_r.ctrl_b[0][cmpctl_pkg::B_FALL] |=> st_r.irq_stat[0])
    else $error("enabled falling edge did not set flag 0");
  AST_NO_EDGE_NO_SET: assert property (
    !st_r.irq_stat[0] && !rise[0] && !fall[0] |=> !st_r.irq_stat[0])
    else $error("flag 0 set without an enabled edge");
  AST_MIRROR: assert property (
    s_axi_arvalid && st_r.arready && s_axi_araddr == cmpctl_pkg::OFS_MIRROR
    |=> s_axi_rvalid && s_axi_rdata == {30'h0, $past(res)})
    else $error("mirror read returned wrong data");
  AST_ANALOG_ZERO: assert property (
    s_axi_arvalid && st_r.arready && s_axi_araddr == cmpctl_pkg::OFS_PORT
    |=> (s_axi_rdata[7:0] & $past(st_r.ansel)) == 8'h00)
    else $error("analog pin read as nonzero");
  AST_PIN_DRIVE: assert property (
    !st_r.ctrl_a[0][cmpctl_pkg::A_PIN_OE] |=> cmp_pin_oe_n[0])
    else $error("pin 0 driven with output enable clear");
  // A disabled core must have every input switch open, whatever the selects hold.
  AST_CORE_OFF: assert property (
    !st_r.ctrl_a[0][cmpctl_pkg::A_ENABLE] |-> cmp_core_ctrl[0][8:0] == 9'h000)
    else $error("disabled core 0 has an input switch closed");
  AST_NEG_ONEHOT: assert property (
    st_r.ctrl_a[1][cmpctl_pkg::A_ENABLE] |-> $onehot(cmp_core_ctrl[1].neg_pin))
    else $error("enabled core 1 has no single negative input");
  AST_IRQ_LEVEL: assert property ((st_r.irq_stat & st_r.irq_en) == '0 |-> !irq)
    else $error("interrupt high with no enabled flag");
  CVR_FLAG_SET: cover property (rise[0] ##1 st_r.irq_stat[0]);
  CVR_IRQ: cover property ($rose(irq));
  CVR_CORE_GND: cover property (cmp_core_ctrl[1].pos_gnd);
  CVR_SET_WINS: cover property (rise[1] && st_r.ctrl_b[1][cmpctl_pkg::B_RISE]
    && st_r.aw_have && st_r.w_have && st_r.awaddr == cmpctl_pkg::OFS_IRQ_CLR);

endmodule // cmpctl_top

// File: verif/cmpctl_far_model.sv
// Far-side model: the two analog comparator cores and the timer clock.
// Assumes the bench sets input levels and starts or stops the timer.
`timescale 1ns/1ps
module cmpctl_far_model (
  input  wire logic        clk,
  input  wire logic [15:0] vp,
  input  wire logic [15:0] vn,
  input  wire logic        tmr_run,
  output logic [1:0]       cmp_raw,
  output logic             tmr1_clk
);
  logic [1:0] div_r = 2'h0;

  // Each core reports high while its positive level is above the negative one.
  assign cmp_raw = {vp[15:8] > vn[15:8], vp[7:0] > vn[7:0]};
  // The timer clock stands low while stopped, so no falling edge can latch.
  always @(posedge clk) begin
    div_r    <= tmr_run ? div_r + 2'h1 : 2'h0;
    tmr1_clk <= tmr_run & div_r[1];
  end
endmodule // cmpctl_far_model

// File: verif/cmpctl_top_tb.sv
// Bench for the dual comparator control block, driven over its register bus.
// Assumes the far-side model supplies the comparator decisions and timer clock.
`timescale 1ns/1ps
module cmpctl_top_tb;
  logic        clk, arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tmr_run = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, port_pin_in = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [15:0] vp = 16'h0000, vn = 16'h4040;
  logic [1:0]  pin_direction_bit = 2'h3, c;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        tmr1_clk;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cmp_raw, cmp_pin_out, cmp_pin_oe_n, cmp_timer1_out;
  cmpctl_pkg::cmpctl_core_t [1:0] cmp_core_ctrl;
  int          bad_count, checked;

  cmpctl_top i_cmpctl_top (.clk, .arst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw,
    .tmr1_clk, .pin_direction_bit, .port_pin_in, .cmp_core_ctrl, .cmp_pin_out, .cmp_pin_oe_n,
    .cmp_timer1_out, .irq);
  cmpctl_far_model i_cmpctl_far_model (.clk, .vp, .vn, .tmr_run, .cmp_raw, .tmr1_clk);

  // A 25 ns period gives the 40 MHz block clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Comparisons and the closing verdict.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Offsets past the last register must be refused with an error response.
  function automatic logic [31:0] resp_of(input logic [7:0] a);
    resp_of = {30'h0, a > cmpctl_pkg::OFS_ANSEL ? cmpctl_pkg::RESP_SLVERR : cmpctl_pkg::RESP_OKAY};
  endfunction
  // Expected core controls for select code c; the second core runs without hysteresis.
  function automatic logic [31:0] core_exp(input logic [1:0] c, input logic s);
    core_exp = {19'h0, 2'b11, !s, c == 2'h0, c == 2'h1, c == 2'h2, c == 2'h3 && !s,
                c == 2'h3 && s, 4'h1 << c};
  endfunction

  // Bus tasks end one edge after the answer so no strobe is driven twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) begin
      bad_count++;
      final_report();
    end
    chk({30'h0, s_axi_bresp}, resp_of(a));
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) begin
      bad_count++;
      final_report();
    end
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, resp_of(a));
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Main sequence: reset values, fields, selects, interrupts, pins, refusal.
  initial begin
    w(5);
    arst_n <= 1'b1;
    w(1);
    rd(cmpctl_pkg::OFS_CTRL_A0, 32'h04);
    rd(cmpctl_pkg::OFS_MIRROR, 32'h00);
    rd(cmpctl_pkg::OFS_PORT, 32'h00);
    wr(cmpctl_pkg::OFS_ANSEL, 32'h0F);
    rd(cmpctl_pkg::OFS_PORT, 32'hF0);
    wr(cmpctl_pkg::OFS_CTRL_A0, 32'hFFFFFF8E);
    wr(cmpctl_pkg::OFS_CTRL_A1, 32'h84);
    rd(cmpctl_pkg::OFS_CTRL_A0, 32'h86);
    vp <= 16'h8080;
    w(6);
    rd(cmpctl_pkg::OFS_CTRL_A0, 32'hC6);
    wr(cmpctl_pkg::OFS_CTRL_A1, 32'h94);
    w(6);
    rd(cmpctl_pkg::OFS_CTRL_A1, 32'h94);
    rd(cmpctl_pkg::OFS_MIRROR, 32'h01);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(cmpctl_pkg::OFS_CTRL_B0, {24'h0, c, 2'h3, c});
      wr(cmpctl_pkg::OFS_CTRL_B1, {24'h0, c, 2'h3, c});
      w(2);
      rd(cmpctl_pkg::OFS_CTRL_B1, {24'h0, c, 2'h0, c});
      chk({19'h0, cmp_core_ctrl[0]}, core_exp(c, 1'b0));
      chk({19'h0, cmp_core_ctrl[1]}, core_exp(c, 1'b1));
    end
    wr(cmpctl_pkg::OFS_CTRL_A0, 32'h80);
    chk({19'h0, cmp_core_ctrl[0]}, 32'h828);
    wr(cmpctl_pkg::OFS_IRQ_EN, 32'h03);
    wr(cmpctl_pkg::OFS_CTRL_B0, 32'h80);
    vp <= 16'h8000;
    w(6);
    rd(cmpctl_pkg::OFS_IRQ_STAT, 32'h00);
    vp <= 16'h8080;
    w(6);
    rd(cmpctl_pkg::OFS_IRQ_STAT, 32'h01);
    chk({31'h0, irq}, 32'h1);
    wr(cmpctl_pkg::OFS_IRQ_EN, 32'h00);
    w(2);
    chk({31'h0, irq}, 32'h0);
    wr(cmpctl_pkg::OFS_IRQ_EN, 32'h03);
    wr(cmpctl_pkg::OFS_IRQ_CLR, 32'h01);
    rd(cmpctl_pkg::OFS_IRQ_STAT, 32'h00);
    chk({31'h0, irq}, 32'h0);
    wr(cmpctl_pkg::OFS_CTRL_B0, 32'h40);
    vp <= 16'h8000;
    w(6);
    rd(cmpctl_pkg::OFS_IRQ_STAT, 32'h01);
    wr(cmpctl_pkg::OFS_CTRL_A0, 32'h06);
    chk({19'h0, cmp_core_ctrl[0]}, 32'h600);
    wr(cmpctl_pkg::OFS_CTRL_B0, 32'hC0);
    wr(cmpctl_pkg::OFS_IRQ_CLR, 32'h01);
    wr(cmpctl_pkg::OFS_CTRL_A0, 32'h16);
    w(6);
    rd(cmpctl_pkg::OFS_IRQ_STAT, 32'h01);
    pin_direction_bit <= 2'h0;
    wr(cmpctl_pkg::OFS_CTRL_A0, 32'h36);
    wr(cmpctl_pkg::OFS_CTRL_A1, 32'hB4);
    w(3);
    chk({30'h0, cmp_pin_oe_n}, 32'h0);
    chk({30'h0, cmp_pin_out}, 32'h1);
    pin_direction_bit <= 2'h3;
    w(3);
    chk({30'h0, cmp_pin_oe_n}, 32'h3);
    wr(cmpctl_pkg::OFS_CTRL_A1, 32'hB5);
    vp <= 16'h0000;
    w(8);
    rd(cmpctl_pkg::OFS_MIRROR, 32'h03);
    chk({30'h0, cmp_timer1_out}, 32'h1);
    tmr_run <= 1'b1;
    w(30);
    chk({30'h0, cmp_timer1_out}, 32'h3);
    chk({30'h0, cmp_pin_out}, 32'h3);
    wr(8'h3C, 32'hFF);
    rd(8'h3C, 32'h00);
    final_report();
  end
endmodule // cmpctl_top_tb
